/* File: hw/fawg_top.sv */
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "fawg_defs.svh"
module fawg_top
  import fawg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IN_CIRCUIT_PROGRAMMING,
  input wire logic HALT,
  input wire logic MEM_REQ,
  input wire logic MEM_WRITE,
  input wire logic [23:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  output logic MEM_ACK,
  output logic MEM_ERR,
  output logic MEM_BUSY,
  output logic [31:0] MEM_RDATA,
  output logic [2:0] MEM_AREA,
  output logic MEM_VECTOR,
  output logic ARR_RE,
  output logic ARR_WE,
  output logic [23:0] ARR_ADDR,
  output logic [31:0] ARR_WDATA,
  input wire logic [31:0] ARR_RDATA,
  input wire logic ARR_OP_DONE,
  output logic ARR_PWRDN,
  output logic FLASH_IRQ
);

  // ****************************************
  // geometry functions
  // ****************************************
  function automatic logic [23:0] prog_bytes(input fawg_dens_t d);
    prog_bytes = (d == DENS_LOW) ? `FAWG_PROG_LOW :
                 (d == DENS_MED) ? `FAWG_PROG_MED : `FAWG_PROG_HIGH;
  endfunction : prog_bytes

  function automatic logic [23:0] data_bytes(input fawg_dens_t d);
    data_bytes = (d == DENS_LOW) ? `FAWG_DATA_LOW :
                 (d == DENS_MED) ? `FAWG_DATA_MED : `FAWG_DATA_HIGH;
  endfunction : data_bytes

  function automatic logic [23:0] page_of(input logic [23:0] off, input fawg_dens_t d);
    page_of = (d == DENS_LOW) ? (off >> `FAWG_PAGE_SH_LOW) : (off >> `FAWG_PAGE_SH_BIG);
  endfunction : page_of

  // larger parts count two extra pages once the size passes one
  function automatic logic [23:0] boot_pages(input logic [7:0] n, input fawg_dens_t d);
    if (d != DENS_LOW && n > 8'h01) begin
      boot_pages = {16'h0000, n} + `FAWG_MED_ADD;
    end else begin
      boot_pages = {16'h0000, n};
    end
  endfunction : boot_pages

  // ****************************************
  // state
  // ****************************************
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic [10:0] opt_reg, opt_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic eop_reg, eop_next, ill_reg, ill_next;
  logic pul_reg, pul_next, dul_reg, dul_next;
  logic pul_set, dul_set;
  fawg_key_t pk_reg, pk_next, dk_reg, dk_next;
  fawg_mem_t mst_reg, mst_next;
  logic arr_re_reg, arr_re_next, arr_we_reg, arr_we_next;
  logic [23:0] arr_addr_reg;
  logic [31:0] arr_wdata_reg, rdata_reg;
  logic ack_reg, ack_next, err_reg, pend_err_reg, busy_reg;
  fawg_area_t area_reg;
  logic vec_reg, pwrdn_reg, irq_reg;

  // ****************************************
  // apb decode
  // ****************************************
  wire apb_acc = PSEL & PENABLE & ~pready_reg;
  wire apb_wr = PSEL & PENABLE & pready_reg & PWRITE & ~pslverr_reg;
  wire hit_opt = PADDR == `FAWG_OPT_OFS;
  wire hit_pukr = PADDR == `FAWG_PUKR_OFS;
  wire hit_dukr = PADDR == `FAWG_DUKR_OFS;
  wire hit_stat = PADDR == `FAWG_STAT_OFS;
  wire hit_ctrl = PADDR == `FAWG_CTRL_OFS;
  wire hit_any = hit_opt | hit_pukr | hit_dukr | hit_stat | hit_ctrl;
  wire stat_wr = apb_wr & hit_stat;
  wire [7:0] key = PWDATA[7:0];
  // key registers read back as zero, the keys are never stored
  wire [31:0] rd_mux = hit_opt ? {21'h00_0000, opt_reg} :
                       hit_stat ? {27'h000_0000, pwrdn_reg, dul_reg, pul_reg, ill_reg, eop_reg} :
                       hit_ctrl ? {30'h0000_0000, ctrl_reg} : 32'h0000_0000;
  assign prdata_next = apb_acc ? rd_mux : prdata_reg;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= apb_acc;
      pslverr_reg <= apb_acc & ~hit_any;
      prdata_reg <= prdata_next;
    end
  end

  // ****************************************
  // option and control
  // ****************************************
  wire [7:0] boot_size = opt_reg[7:0];
  wire ws = opt_reg[`FAWG_WS_BIT];
  wire fawg_dens_t dens = fawg_dens_t'(opt_reg[10:9]);
  // software may only change the options in programming mode
  assign opt_next = (apb_wr & hit_opt & IN_CIRCUIT_PROGRAMMING) ? PWDATA[10:0] :
                    opt_reg;
  assign ctrl_next = (apb_wr & hit_ctrl) ? PWDATA[1:0] : ctrl_reg;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      opt_reg <= `FAWG_OPT_RST;
      ctrl_reg <= `FAWG_CTRL_RST;
    end else begin
      opt_reg <= opt_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************
  // unlock key sequencers
  // ****************************************
  // a wrong first program key locks the port until reset
  always_comb begin
    pk_next = pk_reg;
    pul_set = 1'b0;
    if (apb_wr & hit_pukr) begin
      case (pk_reg)
        KEY_FIRST: pk_next = (key == `FAWG_PKEY1) ? KEY_SECOND : KEY_DEAD;
        KEY_SECOND: begin
          pk_next = (key == `FAWG_PKEY2) ? KEY_FIRST : KEY_DEAD;
          pul_set = key == `FAWG_PKEY2;
        end
        default: pk_next = KEY_DEAD;
      endcase
    end
  end

  // a wrong first data key may simply be retried
  always_comb begin
    dk_next = dk_reg;
    dul_set = 1'b0;
    if (apb_wr & hit_dukr) begin
      case (dk_reg)
        KEY_FIRST: dk_next = (key == `FAWG_DKEY1) ? KEY_SECOND : KEY_FIRST;
        KEY_SECOND: begin
          dk_next = (key == `FAWG_DKEY2) ? KEY_FIRST : KEY_DEAD;
          dul_set = key == `FAWG_DKEY2;
        end
        default: dk_next = KEY_DEAD;
      endcase
    end
  end

  // unlock set wins over a clear written in the same cycle
  assign pul_next = pul_set | (pul_reg & ~(stat_wr & ~PWDATA[`FAWG_PUL_BIT]));
  assign dul_next = dul_set | (dul_reg & ~(stat_wr & ~PWDATA[`FAWG_DUL_BIT]));

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pk_reg <= KEY_FIRST;
      dk_reg <= KEY_FIRST;
      pul_reg <= 1'b0;
      dul_reg <= 1'b0;
    end else begin
      pk_reg <= pk_next;
      dk_reg <= dk_next;
      pul_reg <= pul_next;
      dul_reg <= dul_next;
    end
  end

  // ****************************************
  // area decode
  // ****************************************
  wire [23:0] p_off = MEM_ADDR - `FAWG_PROG_BASE;
  wire [23:0] d_off = MEM_ADDR - `FAWG_DATA_BASE;
  wire [23:0] d_size = data_bytes(dens);
  wire [23:0] optb = (dens == DENS_LOW) ? `FAWG_OPTB_LOW : `FAWG_OPTB_BIG;
  wire in_prog = (MEM_ADDR >= `FAWG_PROG_BASE) && (p_off < prog_bytes(dens));
  wire in_data = (MEM_ADDR >= `FAWG_DATA_BASE) && (d_off < d_size);
  wire [23:0] p_page = page_of(p_off, dens);
  wire in_boot = in_prog && (p_page < boot_pages(boot_size, dens));
  wire in_vec = in_prog && (p_page < `FAWG_VEC_PAGES);
  wire in_optb = in_data && (d_off >= d_size - optb);
  wire fawg_area_t area = in_boot ? AREA_BOOT : in_prog ? AREA_MAIN :
                          in_optb ? AREA_OPT : in_data ? AREA_DATA : AREA_NONE;
  // keys never reach the boot area; unmapped writes count as illegal too
  wire wr_prot = in_boot | (in_prog & ~pul_reg) | (in_data & ~dul_reg) |
                 (area == AREA_NONE);
  wire acc = (mst_reg == MEM_IDLE) & MEM_REQ;
  wire bad_wr = acc & MEM_WRITE & wr_prot;

  // ****************************************
  // access sequencer
  // ****************************************
  always_comb begin
    mst_next = mst_reg;
    arr_re_next = 1'b0;
    arr_we_next = 1'b0;
    ack_next = 1'b0;
    case (mst_reg)
      MEM_IDLE: if (MEM_REQ) begin
        mst_next = ws ? MEM_WAIT : MEM_CAP;
        arr_re_next = ~MEM_WRITE & (area != AREA_NONE);
        arr_we_next = MEM_WRITE & ~wr_prot;
      end
      MEM_WAIT: begin
        mst_next = MEM_CAP;
        arr_re_next = arr_re_reg;
      end
      MEM_CAP: begin
        mst_next = MEM_IDLE;
        ack_next = 1'b1;
      end
      default: mst_next = MEM_IDLE;
    endcase
  end

  wire cap = mst_reg == MEM_CAP;
  wire [31:0] rdata_next = cap ? (arr_re_reg ? ARR_RDATA : 32'h0000_0000) : rdata_reg;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mst_reg <= MEM_IDLE;
      arr_re_reg <= 1'b0;
      arr_we_reg <= 1'b0;
      ack_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      mst_reg <= mst_next;
      arr_re_reg <= arr_re_next;
      arr_we_reg <= arr_we_next;
      ack_reg <= ack_next;
      busy_reg <= mst_next != MEM_IDLE;
    end
  end

  // word aligned, the two low address bits are dropped
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      arr_addr_reg <= 24'h00_0000;
      arr_wdata_reg <= 32'h0000_0000;
      area_reg <= AREA_NONE;
      vec_reg <= 1'b0;
      pend_err_reg <= 1'b0;
    end else if (acc) begin
      arr_addr_reg <= {MEM_ADDR[23:2], 2'b00};
      arr_wdata_reg <= MEM_WDATA;
      area_reg <= area;
      vec_reg <= in_vec;
      pend_err_reg <= MEM_WRITE ? wr_prot : (area == AREA_NONE);
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= cap & pend_err_reg;
    end
  end

  // ****************************************
  // status flags and interrupt
  // ****************************************
  // a new event beats a write-one clear in the same cycle
  assign eop_next = ARR_OP_DONE | (eop_reg & ~(stat_wr & PWDATA[`FAWG_EOP_BIT]));
  assign ill_next = bad_wr | (ill_reg & ~(stat_wr & PWDATA[`FAWG_ILL_BIT]));
  wire irq_next = ctrl_reg[`FAWG_IE_BIT] & (eop_next | ill_next);
  wire pwrdn_next = HALT & ctrl_reg[`FAWG_PD_BIT];

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      eop_reg <= 1'b0;
      ill_reg <= 1'b0;
      irq_reg <= 1'b0;
      pwrdn_reg <= 1'b0;
    end else begin
      eop_reg <= eop_next;
      ill_reg <= ill_next;
      irq_reg <= irq_next;
      pwrdn_reg <= pwrdn_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign MEM_ACK = ack_reg;
  assign MEM_ERR = err_reg;
  assign MEM_BUSY = busy_reg;
  assign MEM_RDATA = rdata_reg;
  assign MEM_AREA = area_reg;
  assign MEM_VECTOR = vec_reg;
  assign ARR_RE = arr_re_reg;
  assign ARR_WE = arr_we_reg;
  assign ARR_ADDR = arr_addr_reg;
  assign ARR_WDATA = arr_wdata_reg;
  assign ARR_PWRDN = pwrdn_reg;
  assign FLASH_IRQ = irq_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  sequence s_rd_fast;
    acc && !MEM_WRITE && !ws;
  endsequence
  sequence s_rd_slow;
    acc && !MEM_WRITE && ws;
  endsequence
  sequence s_drop;
    !ARR_WE ##[1:2] (MEM_ACK && MEM_ERR);
  endsequence

  property p_boot_locked;
    ARR_WE |-> MEM_AREA != AREA_BOOT;
  endproperty
  a_boot_locked: assert property (p_boot_locked) else $error("boot area written");
  property p_no_boot;
    (acc && boot_size == 8'h00) |=> MEM_AREA != AREA_BOOT;
  endproperty
  a_no_boot: assert property (p_no_boot) else $error("boot area with zero size");
  // sizes past the 128 pages of the array are left out
  property p_low_edge;
    (acc && dens == DENS_LOW && boot_size != 8'h00 && boot_size <= 8'h80 &&
     MEM_ADDR == `FAWG_PROG_BASE + {10'h000, boot_size, 6'h00} - 24'h00_0004)
      |=> MEM_AREA == AREA_BOOT;
  endproperty
  a_low_edge: assert property (p_low_edge) else $error("low boot last word wrong");
  property p_med_edge;
    (acc && dens == DENS_MED && boot_size > 8'h01 && boot_size < 8'h3E &&
     MEM_ADDR == `FAWG_PROG_BASE + {7'h00, boot_size + 8'h02, 9'h000} - 24'h00_0004)
      |=> MEM_AREA == AREA_BOOT;
  endproperty
  a_med_edge: assert property (p_med_edge) else $error("medium boot size wrong");
  property p_ws0;
    s_rd_fast |=> !MEM_ACK ##1 MEM_ACK;
  endproperty
  a_ws0: assert property (p_ws0) else $error("read without wait state late");
  property p_ws1;
    s_rd_slow |=> !MEM_ACK [*2] ##1 MEM_ACK;
  endproperty
  a_ws1: assert property (p_ws1) else $error("read with wait state wrong");
  property p_data_lock;
    (ARR_WE && (MEM_AREA == AREA_DATA || MEM_AREA == AREA_OPT)) |-> $past(dul_reg);
  endproperty
  a_data_lock: assert property (p_data_lock) else $error("locked data written");
  property p_main_lock;
    (ARR_WE && MEM_AREA == AREA_MAIN) |-> $past(pul_reg);
  endproperty
  a_main_lock: assert property (p_main_lock) else $error("locked main written");
  property p_irq;
    (bad_wr && ctrl_reg[`FAWG_IE_BIT]) |=> FLASH_IRQ && ill_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("illegal write no interrupt");
  property p_opt_guard;
    (apb_wr && hit_opt && !IN_CIRCUIT_PROGRAMMING) |=> $stable(opt_reg);
  endproperty
  a_opt_guard: assert property (p_opt_guard) else $error("option changed outside prog mode");
  property p_pwrdn;
    (HALT && ctrl_reg[`FAWG_PD_BIT]) |=> ARR_PWRDN;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("array not powered down");
  property p_pkey;
    (apb_wr && hit_pukr && pk_reg == KEY_SECOND && key == `FAWG_PKEY2) |=> pul_reg;
  endproperty
  a_pkey: assert property (p_pkey) else $error("program unlock missed");
  property p_dkey_retry;
    (apb_wr && hit_dukr && dk_reg == KEY_FIRST && key != `FAWG_DKEY1) |=> dk_reg == KEY_FIRST;
  endproperty
  a_dkey_retry: assert property (p_dkey_retry) else $error("data key retry lost");
  property p_drop;
    bad_wr |=> s_drop;
  endproperty
  a_drop: assert property (p_drop) else $error("protected write not dropped");
endmodule : fawg_top

/* File: hw/fawg_defs.svh */
`ifndef FAWG_DEFS_SVH
`define FAWG_DEFS_SVH
// ****************************************
// What this block does
// - boot area never writable, keys included
// - boot pages counted from program base
// - boot size zero means no boot area
// - low density: 64-byte pages, count direct
// - medium density: count plus two above one
// - medium density: 512-byte pages, 32K max
// - high density: 512-byte pages, 128K max
// - low density data: 640 bytes, option block
// - medium density data: 1K, 128-byte options
// - high density data: 2K, 128-byte options
// - arrays addressed as 32-bit words
// - optional single read wait state
// - data area locked until key unlock
// - main area locked until key unlock
// - interrupt on operation end, illegal write
// - low density: two vector pages
// - larger densities: two vector pages
// - boot size writable only in programming mode
// - arrays power down in halt if chosen
// - program keys 0x56 then 0xAE
// - data keys 0xAE then 0x56
// ****************************************

// ****************************************
// register map
// ****************************************
`define FAWG_OPT_OFS 12'h000
`define FAWG_PUKR_OFS 12'h004
`define FAWG_DUKR_OFS 12'h008
`define FAWG_STAT_OFS 12'h00C
`define FAWG_CTRL_OFS 12'h010
`define FAWG_WS_BIT 8
`define FAWG_OPT_RST 11'h400
`define FAWG_CTRL_RST 2'h0
`define FAWG_EOP_BIT 0
`define FAWG_ILL_BIT 1
`define FAWG_PUL_BIT 2
`define FAWG_DUL_BIT 3
`define FAWG_IE_BIT 0
`define FAWG_PD_BIT 1
`define FAWG_PKEY1 8'h56
`define FAWG_PKEY2 8'hAE
`define FAWG_DKEY1 8'hAE
`define FAWG_DKEY2 8'h56

// ****************************************
// memory geometry
// ****************************************
`define FAWG_PROG_BASE 24'h00_8000
`define FAWG_DATA_BASE 24'h00_4000
`define FAWG_PROG_LOW 24'h00_2000
`define FAWG_PROG_MED 24'h00_8000
`define FAWG_PROG_HIGH 24'h02_0000
`define FAWG_DATA_LOW 24'h00_0280
`define FAWG_DATA_MED 24'h00_0400
`define FAWG_DATA_HIGH 24'h00_0800
`define FAWG_OPTB_LOW 24'h00_0040
`define FAWG_OPTB_BIG 24'h00_0080
`define FAWG_PAGE_SH_LOW 6
`define FAWG_PAGE_SH_BIG 9
`define FAWG_VEC_PAGES 24'h00_0002
`define FAWG_MED_ADD 24'h00_0002
`endif

/* File: hw/fawg_pkg.sv */
package fawg_pkg;
  typedef enum logic [1:0] {DENS_LOW, DENS_MED, DENS_HIGH} fawg_dens_t;
  typedef enum logic [2:0] {AREA_NONE, AREA_BOOT, AREA_MAIN, AREA_DATA, AREA_OPT} fawg_area_t;
  typedef enum logic [1:0] {KEY_FIRST, KEY_SECOND, KEY_DEAD} fawg_key_t;
  typedef enum logic [1:0] {MEM_IDLE, MEM_WAIT, MEM_CAP} fawg_mem_t;
endpackage : fawg_pkg

/* File: verification/fawg_array_model.sv */
`timescale 1ns/1ps
// ****************************************
// array model: word store, erased reads ones
// ****************************************
module fawg_array_model (
  input wire logic clk,
  input wire logic arr_re,
  input wire logic arr_we,
  input wire logic [23:0] arr_addr,
  input wire logic [31:0] arr_wdata,
  output logic [31:0] arr_rdata,
  output logic arr_op_done
);
  logic [31:0] mem [logic [23:0]];
  logic [31:0] last_reg = 32'h0000_0000;
  initial arr_op_done = 1'b0;
  always @(posedge clk) begin
    arr_op_done <= arr_we;
    if (arr_we) begin
      mem[arr_addr] = arr_wdata;
    end
    if (arr_re) begin
      last_reg <= arr_rdata;
    end
  end
  // idle bus shows the inverse, so stale data never passes for a read
  always @(arr_re or arr_addr or last_reg) begin
    if (!arr_re) begin
      arr_rdata = ~last_reg;
    end else if (mem.exists(arr_addr)) begin
      arr_rdata = mem[arr_addr];
    end else begin
      arr_rdata = 32'hFFFF_FFFF;
    end
  end
endmodule : fawg_array_model

/* File: verification/fawg_top_tb.sv */
`timescale 1ns/1ps
`include "fawg_defs.svh"
module fawg_top_tb
  import fawg_pkg::*;
;
  logic mclk, rstn, psel, penable, pwrite, in_circuit_programming, halt, er;
  logic mem_req, mem_write, mem_ack, mem_err, mem_busy, mem_vector;
  logic pready, pslverr, arr_re, arr_we, arr_op_done, arr_pwrdn, flash_irq;
  logic [11:0] paddr;
  logic [23:0] mem_addr, arr_addr;
  logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, arr_wdata, arr_rdata, rd;
  logic [2:0] mem_area;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int lat;
  localparam logic [31:0] OPTV [3] = '{32'h0000_0000, 32'h0000_0200, 32'h0000_0400};
  localparam logic [23:0] DSZ [3] = '{24'h00_0280, 24'h00_0400, 24'h00_0800};
  localparam logic [23:0] OSZ [3] = '{24'h00_0040, 24'h00_0080, 24'h00_0080};
  localparam logic [23:0] PSZ [3] = '{24'h00_2000, 24'h00_8000, 24'h02_0000};
  localparam logic [23:0] VSZ [3] = '{24'h00_0080, 24'h00_0400, 24'h00_0400};
  fawg_top i_fawg_top (
    .MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IN_CIRCUIT_PROGRAMMING(in_circuit_programming),
    .HALT(halt), .MEM_REQ(mem_req),
    .MEM_WRITE(mem_write), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_ACK(mem_ack), .MEM_ERR(mem_err), .MEM_BUSY(mem_busy),
    .MEM_RDATA(mem_rdata), .MEM_AREA(mem_area), .MEM_VECTOR(mem_vector),
    .ARR_RE(arr_re), .ARR_WE(arr_we), .ARR_ADDR(arr_addr), .ARR_WDATA(arr_wdata),
    .ARR_RDATA(arr_rdata), .ARR_OP_DONE(arr_op_done), .ARR_PWRDN(arr_pwrdn),
    .FLASH_IRQ(flash_irq)
  );
  fawg_array_model i_fawg_array_model (
    .clk(mclk), .arr_re(arr_re), .arr_we(arr_we), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_op_done(arr_op_done)
  );
  // ****************************************
  // clock, watchdog, helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("unexpected at %0t: run hung", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, m);
  endtask : rchk
  task automatic mop(input logic w, input logic [23:0] a, input logic [31:0] d);
    @(posedge mclk);
    mem_req <= 1'b1;
    mem_write <= w;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge mclk);
    mem_req <= 1'b0;
    lat = 0;
    do begin
      @(posedge mclk);
      lat++;
      if (lat == 1) chk({31'h0, mem_busy}, 32'h0000_0001, "busy after request");
    end while (mem_ack !== 1'b1);
    rd = mem_rdata;
    er = mem_err;
    chk({31'h0, mem_busy}, 32'h0000_0000, "busy at ack");
  endtask : mop
  task automatic wchk(input logic [23:0] a, input logic e, input string m);
    mop(1'b1, a, 32'h0BAD_0000 | 32'(a));
    chk({31'h0, er}, {31'h0, e}, m);
  endtask : wchk
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rchk(`FAWG_OPT_OFS, 32'h0000_0400, "opt reset");
    rchk(`FAWG_STAT_OFS, 32'h0000_0000, "stat reset");
    rchk(`FAWG_CTRL_OFS, 32'h0000_0000, "ctrl reset");
    rchk(12'h020, 32'h0000_0000, "unmapped data");
    chk({31'h0, er}, 32'h0000_0001, "unmapped slverr");
    $display("test reset done");
  endtask : t_reset
  task automatic t_locks();
    wchk(24'h00_9000, 1'b1, "main locked");
    wchk(24'h00_4000, 1'b1, "data locked");
    mop(1'b0, 24'h00_9000, 32'h0000_0000);
    chk(rd, 32'hFFFF_FFFF, "dropped write");
    rchk(`FAWG_STAT_OFS, 32'h0000_0002, "ill flag");
    apb(1'b1, `FAWG_STAT_OFS, 32'h0000_0002);
    $display("test locks done");
  endtask : t_locks
  task automatic t_keys();
    apb(1'b1, `FAWG_PUKR_OFS, 32'h0000_0056);
    apb(1'b1, `FAWG_PUKR_OFS, 32'h0000_00AE);
    rchk(`FAWG_STAT_OFS, 32'h0000_0004, "pul set");
    apb(1'b1, `FAWG_DUKR_OFS, 32'h0000_0011);
    apb(1'b1, `FAWG_DUKR_OFS, 32'h0000_00AE);
    apb(1'b1, `FAWG_DUKR_OFS, 32'h0000_0056);
    rchk(`FAWG_STAT_OFS, 32'h0000_000C, "dul after retry");
    mop(1'b1, 24'h00_9002, 32'hA5A5_0001);
    chk({31'h0, er}, 32'h0000_0000, "main open");
    mop(1'b0, 24'h00_9000, 32'h0000_0000);
    chk(rd, 32'hA5A5_0001, "word readback");
    wchk(24'h00_4004, 1'b0, "data open");
    wchk(24'h00_8000, 1'b0, "no boot area");
    rchk(`FAWG_STAT_OFS, 32'h0000_000D, "eop");
    apb(1'b1, `FAWG_STAT_OFS, 32'h0000_000D);
    $display("test keys done");
  endtask : t_keys
  task automatic t_boot();
    logic [31:0] ov [3] = '{32'h0000_0403, 32'h0000_0203, 32'h0000_0003};
    logic [23:0] edg [3] = '{24'h00_8A00, 24'h00_8A00, 24'h00_80C0};
    apb(1'b1, `FAWG_OPT_OFS, 32'h0000_0403);
    rchk(`FAWG_OPT_OFS, 32'h0000_0400, "opt locked");
    in_circuit_programming <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `FAWG_OPT_OFS, ov[i]);
      rchk(`FAWG_OPT_OFS, ov[i], "opt in prog mode");
      wchk(edg[i] - 24'h00_0004, 1'b1, "boot last word");
      chk(32'(mem_area), 32'(AREA_BOOT), "boot area code");
      wchk(edg[i], 1'b0, "past boot");
    end
    wchk(24'h00_8000, 1'b1, "boot from base");
    $display("test boot done");
  endtask : t_boot
  task automatic t_geom();
    logic [23:0] db;
    logic [23:0] pb;
    db = `FAWG_DATA_BASE;
    pb = `FAWG_PROG_BASE;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `FAWG_OPT_OFS, OPTV[i]);
      mop(1'b0, db + DSZ[i] - 24'h00_0004, 32'h0000_0000);
      chk(32'(mem_area), 32'(AREA_OPT), "option block");
      mop(1'b0, db + DSZ[i] - OSZ[i] - 24'h00_0004, 32'h0000_0000);
      chk(32'(mem_area), 32'(AREA_DATA), "data below options");
      mop(1'b0, db + DSZ[i], 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001, "data end");
      mop(1'b0, pb + PSZ[i] - 24'h00_0004, 32'h0000_0000);
      chk(32'(mem_area), 32'(AREA_MAIN), "prog last");
      mop(1'b0, pb + PSZ[i], 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001, "prog end");
      mop(1'b0, pb + VSZ[i] - 24'h00_0004, 32'h0000_0000);
      chk({31'h0, mem_vector}, 32'h0000_0001, "vector");
      mop(1'b0, pb + VSZ[i], 32'h0000_0000);
      chk({31'h0, mem_vector}, 32'h0000_0000, "past vector");
    end
    $display("test geometry done");
  endtask : t_geom
  task automatic t_ws();
    apb(1'b1, `FAWG_OPT_OFS, 32'h0000_0500);
    mop(1'b0, 24'h00_9000, 32'h0000_0000);
    chk(32'(lat), 32'h0000_0003, "wait state");
    chk(rd, 32'hA5A5_0001, "ws data");
    apb(1'b1, `FAWG_OPT_OFS, 32'h0000_0400);
    mop(1'b0, 24'h00_9000, 32'h0000_0000);
    chk(32'(lat), 32'h0000_0002, "no wait state");
    $display("test wait done");
  endtask : t_ws
  task automatic irq_chk(input logic e, input string m);
    repeat (3) @(posedge mclk);
    chk({31'h0, flash_irq}, {31'h0, e}, m);
  endtask : irq_chk
  task automatic t_irq();
    apb(1'b1, `FAWG_STAT_OFS, 32'h0000_000F);
    apb(1'b1, `FAWG_CTRL_OFS, 32'h0000_0001);
    irq_chk(1'b0, "irq idle");
    wchk(24'h00_9004, 1'b0, "irq write");
    irq_chk(1'b1, "irq on eop");
    apb(1'b1, `FAWG_STAT_OFS, 32'h0000_000D);
    irq_chk(1'b0, "irq cleared");
    wchk(24'h03_0000, 1'b1, "unmapped write");
    irq_chk(1'b1, "irq on illegal");
    apb(1'b1, `FAWG_CTRL_OFS, 32'h0000_0002);
    irq_chk(1'b0, "irq masked");
    apb(1'b1, `FAWG_STAT_OFS, 32'h0000_000E);
    halt <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, arr_pwrdn}, 32'h0000_0001, "power down");
    rchk(`FAWG_STAT_OFS, 32'h0000_001C, "stat pwrdn");
    halt <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, arr_pwrdn}, 32'h0000_0000, "awake");
    $display("test irq done");
  endtask : t_irq
  task automatic t_proglock();
    apb(1'b1, `FAWG_STAT_OFS, 32'h0000_0008);
    apb(1'b1, `FAWG_PUKR_OFS, 32'h0000_0000);
    apb(1'b1, `FAWG_PUKR_OFS, 32'h0000_0056);
    apb(1'b1, `FAWG_PUKR_OFS, 32'h0000_00AE);
    rchk(`FAWG_STAT_OFS, 32'h0000_0008, "program keys dead");
    wchk(24'h00_9000, 1'b1, "main relocked");
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rchk(`FAWG_STAT_OFS, 32'h0000_0000, "locks after reset");
    $display("test program lock done");
  endtask : t_proglock
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, in_circuit_programming, halt, mem_req, mem_write} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mem_addr = 24'h00_0000;
    mem_wdata = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_locks();
    t_keys();
    t_boot();
    t_geom();
    t_ws();
    t_irq();
    t_proglock();
    tally_and_finish();
  end
endmodule : fawg_top_tb
